//--- ssfo_pkg.sv
// Shared constants, types and frame layout for the sensor serial frame output block
package ssfo_pkg;

	// ==========================================================
	// Clock and serial timing
	// ==========================================================
	localparam int unsigned CLK_HZ        = 100_000_000; // mclk rate
	localparam int unsigned BAUD_SLOW_BPS = 9600;        // Default line rate
	localparam int unsigned BAUD_FAST_BPS = 115200;      // Software-selected line rate
	// Bit periods in mclk cycles, rounded to nearest
	localparam int unsigned BAUD_SLOW_DIV = (CLK_HZ + BAUD_SLOW_BPS / 2) / BAUD_SLOW_BPS;
	localparam int unsigned BAUD_FAST_DIV = (CLK_HZ + BAUD_FAST_BPS / 2) / BAUD_FAST_BPS;
	localparam int unsigned DIV_W         = 14;          // Holds the slow divisor
	localparam int unsigned DATA_BITS     = 8;           // 8N1 framing

	typedef logic [DIV_W-1:0] ssfo_div_t;
	typedef logic [7:0]       ssfo_byte_t;

	// ==========================================================
	// Frame layout
	// ==========================================================
	localparam ssfo_byte_t HDR_BYTE     = 8'h5A; // Sent twice at frame start
	localparam ssfo_byte_t TYPE_LIGHT   = 8'h15; // Illuminance frame
	localparam ssfo_byte_t TYPE_ENV     = 8'h45; // Temp/pressure/humidity/altitude
	localparam ssfo_byte_t TYPE_ADDR    = 8'h55; // Bus address frame
	localparam ssfo_byte_t CNT_LIGHT    = 8'h04; // Payload bytes per frame type
	localparam ssfo_byte_t CNT_ENV      = 8'h0A;
	localparam ssfo_byte_t CNT_ADDR     = 8'h01;
	localparam int unsigned FRAME_MAX   = 14;    // Bytes before checksum, largest frame
	localparam int unsigned IDX_W       = 4;
	localparam logic [IDX_W-1:0] POS_TYPE = 4'h2; // Byte positions
	localparam logic [IDX_W-1:0] POS_CNT  = 4'h3;
	localparam logic [IDX_W-1:0] POS_PAY  = 4'h4;

	// ==========================================================
	// Host query framing
	// ==========================================================
	localparam ssfo_byte_t QRY_HDR      = 8'hA5; // Command header
	localparam ssfo_byte_t QRY_LIGHT    = 8'h51; // Ask for light frame
	localparam ssfo_byte_t QRY_ENV      = 8'h52; // Ask for environment frame

	// ==========================================================
	// Reset values and state types
	// ==========================================================
	localparam logic [4:0] SYNC_RST     = 5'h1F; // Pins idle high
	typedef enum logic [1:0] {FR_IDLE, FR_SEND, FR_SUM} ssfo_frame_e;
	typedef enum logic [1:0] {QR_HDR, QR_CMD, QR_SUM} ssfo_query_e;

endpackage : ssfo_pkg

//--- ssfo_uart_if.sv
// Byte channel between the frame controller and the serial line engine
`timescale 1ns/1ns
interface ssfo_uart_if;
	import ssfo_pkg::*;
	ssfo_div_t  div;      // Bit period in mclk cycles
	ssfo_byte_t tx_data;  // Byte to send
	logic       tx_valid; // Byte offered
	logic       tx_ready; // Engine idle, takes byte
	logic       tx_line;  // Serial output level
	logic       rx_line;  // Synchronised serial input
	ssfo_byte_t rx_data;  // Received byte
	logic       rx_valid; // One-cycle pulse per byte with a high stop bit
	logic       rx_err;   // Stop bit low

	modport ctl (output div, tx_data, tx_valid, rx_line,
		input tx_ready, tx_line, rx_data, rx_valid, rx_err);
	modport phy (input div, tx_data, tx_valid, rx_line,
		output tx_ready, tx_line, rx_data, rx_valid, rx_err);
endinterface : ssfo_uart_if

//--- ssfo_uart.sv
// 8N1 serial transmitter and receiver with run-time bit period
`timescale 1ns/1ns
module ssfo_uart (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Byte channel
	ssfo_uart_if.phy u
);
	import ssfo_pkg::*;

	// ==========================================================
	// Transmitter
	// ==========================================================
	logic [9:0]  tx_shift_reg; // Stop, data, start
	logic [3:0]  tx_left_reg;  // Bits still to send
	ssfo_div_t   tx_cnt_reg;   // Bit timer
	ssfo_div_t   tx_div_reg;   // Period latched per byte so a rate change never splits a byte

	assign u.tx_ready = (tx_left_reg == 4'h0);
	assign u.tx_line  = tx_shift_reg[0];

	// Shift one bit per period
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_shift_reg <= 10'h3FF;
			tx_left_reg  <= 4'h0;
			tx_cnt_reg   <= '0;
			tx_div_reg   <= '0;
		end else if (u.tx_ready) begin
			// Load start bit, data LSB first, stop bit
			if (u.tx_valid) begin
				tx_shift_reg <= {1'b1, u.tx_data, 1'b0};
				tx_left_reg  <= 4'hA;
				tx_cnt_reg   <= u.div - 1'b1;
				tx_div_reg   <= u.div;
			end
		end else if (tx_cnt_reg == '0) begin
			// Next bit
			tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
			tx_left_reg  <= tx_left_reg - 1'b1;
			tx_cnt_reg   <= tx_div_reg - 1'b1;
		end else begin
			tx_cnt_reg <= tx_cnt_reg - 1'b1;
		end
	end

	// ==========================================================
	// Receiver
	// ==========================================================
	logic       rx_busy_reg;  // Inside a character
	logic [3:0] rx_bit_reg;   // 0 start, 1..8 data, 9 stop
	ssfo_div_t  rx_cnt_reg;   // Sample timer
	ssfo_byte_t rx_shift_reg; // Data collected LSB first
	ssfo_byte_t rx_data_reg;  // Completed byte
	logic       rx_valid_reg; // Byte pulse
	logic       rx_err_reg;   // Framing error pulse

	assign u.rx_data  = rx_data_reg;
	assign u.rx_valid = rx_valid_reg;
	assign u.rx_err   = rx_err_reg;

	// Sample mid-bit; start edge arms a half-period wait
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_busy_reg  <= 1'b0;
			rx_bit_reg   <= 4'h0;
			rx_cnt_reg   <= '0;
			rx_shift_reg <= '0;
			rx_data_reg  <= '0;
			rx_valid_reg <= 1'b0;
			rx_err_reg   <= 1'b0;
		end else begin
			rx_valid_reg <= 1'b0;
			rx_err_reg   <= 1'b0;
			if (!rx_busy_reg) begin
				// Wait for falling start edge
				if (!u.rx_line) begin
					rx_busy_reg <= 1'b1;
					rx_bit_reg  <= 4'h0;
					rx_cnt_reg  <= {1'b0, u.div[DIV_W-1:1]};
				end
			end else if (rx_cnt_reg != '0) begin
				rx_cnt_reg <= rx_cnt_reg - 1'b1;
			end else begin
				rx_cnt_reg <= u.div - 1'b1;
				rx_bit_reg <= rx_bit_reg + 1'b1;
				if (rx_bit_reg == 4'h0) begin
					// Glitch, not a real start bit
					if (u.rx_line)
						rx_busy_reg <= 1'b0;
				end else if (rx_bit_reg <= 4'(DATA_BITS)) begin
					rx_shift_reg <= {u.rx_line, rx_shift_reg[7:1]};
				end else begin
					// Stop bit decides good or bad byte
					rx_busy_reg  <= 1'b0;
					rx_data_reg  <= rx_shift_reg;
					rx_valid_reg <= u.rx_line;
					rx_err_reg   <= !u.rx_line;
				end
			end
		end
	end

endmodule : ssfo_uart

//--- ssfo_top.sv
// Sensor serial frame output: strap decode, query parse, frame build and send
`timescale 1ns/1ns
module ssfo_top #(
	parameter int unsigned SLOW_DIV = ssfo_pkg::BAUD_SLOW_DIV // Over 4096 cycles
) (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 sys_rst,
	// Strap pins
	input  wire logic                 interface_select_strap,
	input  wire logic                 sensor_bypass_strap,
	// Shared host pins, three-signal form
	input  wire logic                 tx_or_bus_clock_pin_in,
	output logic                      tx_or_bus_clock_pin_out,
	output logic                      tx_or_bus_clock_pin_oe_n,
	input  wire logic                 rx_or_bus_data_pin_in,
	output logic                      rx_or_bus_data_pin_out,
	output logic                      rx_or_bus_data_pin_oe_n,
	// Auxiliary raw sensor bus pins
	input  wire logic                 aux_clock_pin_in,
	output logic                      aux_clock_pin_out,
	output logic                      aux_clock_pin_oe_n,
	input  wire logic                 aux_data_pin_in,
	output logic                      aux_data_pin_out,
	output logic                      aux_data_pin_oe_n,
	// Internal sensor bus side
	input  wire logic                 sens_clock_pull_low,
	input  wire logic                 sens_data_pull_low,
	output logic                      sens_clock_seen,
	output logic                      sens_data_seen,
	// Configuration
	input  wire logic                 baud_fast,
	input  wire logic                 cont_light_en,
	input  wire logic                 cont_env_en,
	// Measurements
	input  wire logic [31:0]          lux_val,
	input  wire logic [15:0]          temp_val,
	input  wire logic [31:0]          press_val,
	input  wire logic [15:0]          hum_val,
	input  wire logic [15:0]          alt_val,
	input  wire logic [6:0]           bus_addr7,
	input  wire logic                 meas_update,
	input  wire logic                 addr_report,
	// Status
	output logic                      serial_mode,
	output logic                      bypass_mode,
	output logic                      frame_busy,
	output logic                      frame_done,
	output logic                      query_err
);
	import ssfo_pkg::*;

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic [4:0] sync1_reg; // First stage, read only by second stage
	logic [4:0] sync2_reg; // Strap0, strap1, rx, aux clock, aux data

	// Two flops on every pin input except the unused TX pin input
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_reg <= SYNC_RST;
			sync2_reg <= SYNC_RST;
		end else begin
			sync1_reg <= {interface_select_strap, sensor_bypass_strap,
				rx_or_bus_data_pin_in, aux_clock_pin_in, aux_data_pin_in};
			sync2_reg <= sync1_reg;
		end
	end

	logic ser_on;    // Serial mode active
	logic proc_on;   // Controller owns the data
	assign ser_on  = sync2_reg[4];
	assign proc_on = sync2_reg[3];

	// ==========================================================
	// Serial engine
	// ==========================================================
	ssfo_uart_if u ();
	ssfo_uart u_uart (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.u       (u.phy)
	);
	assign u.div     = baud_fast ? DIV_W'(BAUD_FAST_DIV) : DIV_W'(SLOW_DIV);
	assign u.rx_line = sync2_reg[2] | !ser_on;

	// ==========================================================
	// Pin drive
	// ==========================================================
	// Registered pin outputs; low enable means driving
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_or_bus_clock_pin_out  <= 1'b1;
			tx_or_bus_clock_pin_oe_n <= 1'b1;
			rx_or_bus_data_pin_out   <= 1'b1;
			rx_or_bus_data_pin_oe_n  <= 1'b1;
			aux_clock_pin_out        <= 1'b0;
			aux_clock_pin_oe_n       <= 1'b1;
			aux_data_pin_out         <= 1'b0;
			aux_data_pin_oe_n        <= 1'b1;
			sens_clock_seen          <= 1'b1;
			sens_data_seen           <= 1'b1;
		end else begin
			// Drive TX only in serial mode
			tx_or_bus_clock_pin_out  <= u.tx_line;
			tx_or_bus_clock_pin_oe_n <= !ser_on;
			// Bus mode releases both shared pins
			rx_or_bus_data_pin_out   <= 1'b1;
			rx_or_bus_data_pin_oe_n  <= 1'b1;
			// Bypass: open-drain pass of sensor bus
			aux_clock_pin_oe_n       <= !(!proc_on && sens_clock_pull_low);
			aux_data_pin_oe_n        <= !(!proc_on && sens_data_pull_low);
			// Host level reaches sensors only in bypass
			sens_clock_seen          <= sync2_reg[1] | proc_on;
			sens_data_seen           <= sync2_reg[0] | proc_on;
		end
	end

	// ==========================================================
	// Host query parser
	// ==========================================================
	ssfo_query_e q_state_reg; // Position within command
	ssfo_byte_t  q_cmd_reg;   // Instruction byte
	logic        q_light;     // Valid light query
	logic        q_env;       // Valid environment query

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			q_state_reg <= QR_HDR;
			q_cmd_reg   <= '0;
			query_err   <= 1'b0;
		end else begin
			query_err <= 1'b0;
			if (u.rx_err) begin
				// Broken character restarts the hunt
				q_state_reg <= QR_HDR;
			end else if (u.rx_valid) begin
				unique case (q_state_reg)
					QR_HDR: begin
						if (u.rx_data == QRY_HDR)
							q_state_reg <= QR_CMD;
					end
					QR_CMD: begin
						q_cmd_reg   <= u.rx_data;
						q_state_reg <= QR_SUM;
					end
					QR_SUM: begin
						query_err   <= (u.rx_data != 8'(QRY_HDR + q_cmd_reg));
						q_state_reg <= QR_HDR;
					end
				endcase
			end
		end
	end

	logic sum_ok; // Checksum byte matches
	assign sum_ok  = u.rx_valid && !u.rx_err && (q_state_reg == QR_SUM)
		&& (u.rx_data == 8'(QRY_HDR + q_cmd_reg));
	assign q_light = sum_ok && (q_cmd_reg == QRY_LIGHT);
	assign q_env   = sum_ok && (q_cmd_reg == QRY_ENV);

	// ==========================================================
	// Frame requests
	// ==========================================================
	logic [2:0] pend_reg; // Light, environment, address
	logic [2:0] pend_set; // New requests this cycle
	logic [2:0] pend_clr; // Taken by frame start
	logic       start;    // Frame begins

	// Light and environment: continuous on update, or on query; address on addr_report
	assign pend_set = {q_light | (meas_update & cont_light_en),
		q_env | (meas_update & cont_env_en), addr_report};

	// Set wins over a same-cycle clear
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			pend_reg <= 3'h0;
		else
			pend_reg <= (pend_reg & ~pend_clr) | pend_set;
	end

	// ==========================================================
	// Frame builder and sender
	// ==========================================================
	ssfo_frame_e      f_state_reg;               // Sender state
	ssfo_byte_t       fbuf_reg [0:FRAME_MAX-1];  // Bytes before checksum
	logic [IDX_W-1:0] f_idx_reg;                 // Byte being offered
	logic [IDX_W-1:0] f_len_reg;                 // Bytes before checksum
	ssfo_byte_t       csum_reg;                  // Running sum
	logic             take;                      // Engine accepted a byte

	assign start = (f_state_reg == FR_IDLE) && ser_on && proc_on && (pend_reg != 3'h0);
	// Fixed priority: light, then environment, then address
	assign pend_clr = !start ? 3'h0 : pend_reg[2] ? 3'h4 : pend_reg[1] ? 3'h2 : 3'h1;
	assign take     = u.tx_valid && u.tx_ready;
	assign u.tx_valid = (f_state_reg != FR_IDLE);
	assign u.tx_data  = (f_state_reg == FR_SUM) ? csum_reg : fbuf_reg[f_idx_reg];

	// Build whole frame at start, then hand bytes over in order
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			f_state_reg <= FR_IDLE;
			f_idx_reg   <= '0;
			f_len_reg   <= '0;
			csum_reg    <= '0;
			for (int i = 0; i < FRAME_MAX; i++)
				fbuf_reg[i] <= '0;
		end else begin
			unique case (f_state_reg)
				FR_IDLE: begin
					if (start) begin
						fbuf_reg[0] <= HDR_BYTE;
						fbuf_reg[1] <= HDR_BYTE;
						f_idx_reg   <= '0;
						csum_reg    <= '0;
						f_state_reg <= FR_SEND;
						if (pend_clr[2]) begin
							fbuf_reg[POS_TYPE] <= TYPE_LIGHT;
							fbuf_reg[POS_CNT] <= CNT_LIGHT;
							f_len_reg <= POS_PAY + IDX_W'(CNT_LIGHT);
							{fbuf_reg[4], fbuf_reg[5], fbuf_reg[6], fbuf_reg[7]} <= lux_val;
						end else if (pend_clr[1]) begin
							fbuf_reg[POS_TYPE] <= TYPE_ENV;
							fbuf_reg[POS_CNT] <= CNT_ENV;
							f_len_reg <= POS_PAY + IDX_W'(CNT_ENV);
							{fbuf_reg[4], fbuf_reg[5]} <= temp_val;
							{fbuf_reg[6], fbuf_reg[7], fbuf_reg[8], fbuf_reg[9]} <= press_val;
							{fbuf_reg[10], fbuf_reg[11]} <= hum_val;
							{fbuf_reg[12], fbuf_reg[13]} <= alt_val;
						end else begin
							fbuf_reg[POS_TYPE] <= TYPE_ADDR;
							fbuf_reg[POS_CNT] <= CNT_ADDR;
							f_len_reg <= POS_PAY + IDX_W'(CNT_ADDR);
							fbuf_reg[POS_PAY] <= {bus_addr7, 1'b0};
						end
					end
				end
				FR_SEND: begin
					if (take) begin
						csum_reg  <= csum_reg + fbuf_reg[f_idx_reg];
						f_idx_reg <= f_idx_reg + 1'b1;
						if (f_idx_reg == f_len_reg - 1'b1)
							f_state_reg <= FR_SUM;
					end
				end
				FR_SUM: begin
					if (take)
						f_state_reg <= FR_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Status outputs
	// ==========================================================
	// Registered mode and progress flags
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			serial_mode <= 1'b1;
			bypass_mode <= 1'b0;
			frame_busy  <= 1'b0;
			frame_done  <= 1'b0;
		end else begin
			serial_mode <= ser_on;
			bypass_mode <= !proc_on;
			frame_busy  <= (f_state_reg != FR_IDLE);
			frame_done  <= (f_state_reg == FR_SUM) && take;
		end
	end

endmodule : ssfo_top

//--- ssfo_chk.sv
// Port-level assertions for the sensor serial frame output block
`timescale 1ns/1ns
module ssfo_chk #(
	parameter int unsigned SLOW_DIV = 16 // Bit period of the slow rate
) (
	// Clock, reset and straps
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic interface_select_strap,
	input wire logic sensor_bypass_strap,
	// Pins
	input wire logic tx_or_bus_clock_pin_out,
	input wire logic tx_or_bus_clock_pin_oe_n,
	input wire logic aux_clock_pin_oe_n,
	input wire logic aux_data_pin_oe_n,
	input wire logic sens_clock_pull_low,
	// Requests and status
	input wire logic cont_light_en,
	input wire logic meas_update,
	input wire logic serial_mode,
	input wire logic bypass_mode,
	input wire logic frame_busy,
	input wire logic frame_done,
	input wire logic query_err
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// Properties
	// ==========================================================
	// Strap settles through two flops plus the status flop, so four cycles just suffice
	property p_serial_sel;
		interface_select_strap[*4] |-> serial_mode ##1 !tx_or_bus_clock_pin_oe_n;
	endproperty
	a_serial_sel: assert property (p_serial_sel) else $error("serial pin not driven");
	property p_bus_rel;
		(!interface_select_strap)[*4] |-> !serial_mode ##1 tx_or_bus_clock_pin_oe_n;
	endproperty
	a_bus_rel: assert property (p_bus_rel) else $error("shared pin not released");
	property p_bus_quiet;
		(!serial_mode)[*3] |-> !$rose(frame_busy);
	endproperty
	a_bus_quiet: assert property (p_bus_quiet) else $error("frame began in bus mode");
	property p_byp_drive;
		bypass_mode && sens_clock_pull_low ##1 bypass_mode |-> !aux_clock_pin_oe_n;
	endproperty
	a_byp_drive: assert property (p_byp_drive) else $error("aux clock not pulled");
	property p_no_bypass;
		sensor_bypass_strap[*4] |-> !bypass_mode;
	endproperty
	a_no_bypass: assert property (p_no_bypass) else $error("bypass with strap high");
	property p_aux_idle;
		!bypass_mode ##1 !bypass_mode |-> aux_clock_pin_oe_n && aux_data_pin_oe_n;
	endproperty
	a_aux_idle: assert property (p_aux_idle) else $error("aux pin driven");
	// Start bit lasts a whole slow bit period, at least eight cycles here
	property p_start_bit;
		$fell(tx_or_bus_clock_pin_out) |-> (!tx_or_bus_clock_pin_out)[*8];
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("start bit too short");
	property p_done_idle;
		frame_done |-> tx_or_bus_clock_pin_out ##1 !frame_done;
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("line not idle at end");
	property p_cont_start;
		meas_update && cont_light_en && serial_mode && !bypass_mode && !frame_busy
			&& interface_select_strap && sensor_bypass_strap |-> ##[1:8] frame_busy;
	endproperty
	a_cont_start: assert property (p_cont_start) else $error("no frame on update");
	property p_qerr_pulse;
		query_err |=> !query_err;
	endproperty
	a_qerr_pulse: assert property (p_qerr_pulse) else $error("query error too long");
	// Main scenarios reached
	c_done: cover property (frame_done);
	c_qerr: cover property (query_err);
	c_byp: cover property (bypass_mode && !aux_clock_pin_oe_n);
endmodule : ssfo_chk

//--- ssfo_host.sv
// Host model: 8N1 receiver of device frames and sender of queries
`timescale 1ns/1ns
module ssfo_host #(
	parameter int unsigned DIV = 16 // Bit period in mclk cycles
) (
	input wire logic mclk,    // Bench clock
	input wire logic tx_line, // Device transmit pin level
	output logic     rx_line  // Device receive pin level
);
	logic [7:0] got [$]; // Bytes decoded from the device
	initial rx_line = 1'b1;
	// 8N1 receive, sampled mid-bit; bad stop bit drops the byte
	initial begin : rx_proc
		logic [7:0] b;
		forever begin
			@(negedge tx_line);
			repeat (DIV / 2) @(posedge mclk);
			if (tx_line == 1'b0) begin
				for (int i = 0; i < 8; i++) begin
					repeat (DIV) @(posedge mclk);
					b[i] = tx_line;
				end
				repeat (DIV) @(posedge mclk);
				if (tx_line == 1'b1) got.push_back(b);
			end
		end
	end
	// One byte, LSB first, changed just after an edge
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_line = f[i];
			repeat (DIV) @(posedge mclk);
			#1;
		end
	endtask : send_byte
	task automatic query(input logic [7:0] h, input logic [7:0] c, input logic [7:0] s);
		send_byte(h);
		send_byte(c);
		send_byte(s);
	endtask : query
endmodule : ssfo_host

//--- tb_top.sv
// Self-checking bench for the sensor serial frame output block
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
	import ssfo_pkg::*;
	localparam int unsigned SLOW_DIV = 16; // Short bit period keeps frames quick
	int failures = 0;
	int check_count = 0;
	logic mclk = 1'b0, sys_rst = 1'b1, sel = 1'b1, byp = 1'b1, ac_ext = 1'b1, ad_ext = 1'b1;
	logic pull_c = 1'b0, pull_d = 1'b0, c_light = 1'b0, c_env = 1'b0, upd = 1'b0, arep = 1'b0;
	logic [31:0] lux = '0, press = '0;
	logic [15:0] temp = '0, hum = '0, alt = '0;
	logic [6:0] addr7 = '0;
	logic tx_out, tx_oe_n, rx_line, rx_out, rx_oe_n, ac_out, ac_oe_n, ad_out, ad_oe_n;
	logic c_seen, d_seen, ser_m, byp_m, busy, done, qerr, fast = 1'b0;
	int qerr_cnt = 0; // Query error pulses seen so far
	wire tx_pin = tx_oe_n ? 1'b1 : tx_out; // Pull-up when released
	wire rx_pin = rx_oe_n ? rx_line : rx_out;
	wire ac_pin = ac_oe_n ? ac_ext : ac_out;
	wire ad_pin = ad_oe_n ? ad_ext : ad_out;
	logic [7:0] exp_q [$]; // Frame predicted by the bench
	always #5 mclk = ~mclk;
	always @(posedge mclk) if (qerr === 1'b1) qerr_cnt <= qerr_cnt + 1;
	ssfo_top #(.SLOW_DIV(SLOW_DIV)) i_ssfo_top (.mclk(mclk), .sys_rst(sys_rst),
		.interface_select_strap(sel), .sensor_bypass_strap(byp),
		.tx_or_bus_clock_pin_in(tx_pin), .tx_or_bus_clock_pin_out(tx_out),
		.tx_or_bus_clock_pin_oe_n(tx_oe_n), .rx_or_bus_data_pin_in(rx_pin),
		.rx_or_bus_data_pin_out(rx_out), .rx_or_bus_data_pin_oe_n(rx_oe_n),
		.aux_clock_pin_in(ac_pin), .aux_clock_pin_out(ac_out), .aux_clock_pin_oe_n(ac_oe_n),
		.aux_data_pin_in(ad_pin), .aux_data_pin_out(ad_out), .aux_data_pin_oe_n(ad_oe_n),
		.sens_clock_pull_low(pull_c), .sens_data_pull_low(pull_d), .sens_clock_seen(c_seen),
		.sens_data_seen(d_seen), .baud_fast(fast), .cont_light_en(c_light),
		.cont_env_en(c_env), .lux_val(lux), .temp_val(temp), .press_val(press),
		.hum_val(hum), .alt_val(alt), .bus_addr7(addr7), .meas_update(upd),
		.addr_report(arep), .serial_mode(ser_m), .bypass_mode(byp_m), .frame_busy(busy),
		.frame_done(done), .query_err(qerr));
	ssfo_host #(.DIV(SLOW_DIV)) i_ssfo_host (.mclk(mclk), .tx_line(tx_pin), .rx_line(rx_line));
	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize
	// Predict a frame, then compare it byte by byte with what the host decoded
	task automatic expect_frame(input logic [7:0] t, input int n, input logic [79:0] pay);
		int s, k;
		logic [7:0] b;
		exp_q = {HDR_BYTE, HDR_BYTE, t, n[7:0]};
		for (int i = n - 1; i >= 0; i--) exp_q.push_back(pay[i*8 +: 8]);
		// Recompute the additive sum as the device does
		s = 0;
		foreach (exp_q[i]) s += exp_q[i];
		exp_q.push_back(s[7:0]);
		foreach (exp_q[i]) begin
			k = 0;
			while (i_ssfo_host.got.size() == 0 && k < 4000) begin cyc(1); k++; end
			if (k == 4000) begin failures++; $display("MISMATCH t=%0t no byte", $time); summarize(); end
			b = i_ssfo_host.got.pop_front();
			`CHK(b, exp_q[i])
		end
	endtask : expect_frame
	task automatic pulse_upd;
		upd = 1'b1;
		cyc(1);
		upd = 1'b0;
	endtask : pulse_upd
	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		int k, q0;
		void'($urandom(80910));
		cyc(8);
		sys_rst = 1'b0;
		cyc(4);
		// Light only, environment only, then both back to back
		for (int r = 0; r < 3; r++) begin
			{lux, press} = {$urandom(), $urandom()};
			{temp, hum, alt} = 48'({$urandom(), $urandom()});
			c_light = (r != 1);
			c_env = (r != 0);
			pulse_upd();
			if (c_light) expect_frame(TYPE_LIGHT, 4, {48'h0, lux});
			if (c_env) expect_frame(TYPE_ENV, 10, {temp, press, hum, alt});
		end
		{c_light, c_env} = 2'b00;
		$display("test continuous done");
		// Address edge values and one random
		for (int r = 0; r < 3; r++) begin
			addr7 = (r == 0) ? 7'h00 : (r == 1) ? 7'h7F : 7'($urandom());
			arep = 1'b1;
			cyc(1);
			arep = 1'b0;
			expect_frame(TYPE_ADDR, 1, {72'h0, addr7, 1'b0});
		end
		$display("test address done");
		// Queries answered with one frame each, none of them flagged
		lux = $urandom();
		q0 = qerr_cnt;
		i_ssfo_host.query(QRY_HDR, QRY_LIGHT, QRY_HDR + QRY_LIGHT);
		expect_frame(TYPE_LIGHT, 4, {48'h0, lux});
		i_ssfo_host.query(QRY_HDR, QRY_ENV, QRY_HDR + QRY_ENV);
		expect_frame(TYPE_ENV, 10, {temp, press, hum, alt});
		// Bad sum flags once, unknown instruction and wrong header stay silent
		i_ssfo_host.query(QRY_HDR, QRY_LIGHT, 8'h00);
		cyc(20);
		`CHK(qerr_cnt - q0, 1)
		i_ssfo_host.query(QRY_HDR, 8'h53, QRY_HDR + 8'h53);
		i_ssfo_host.query(8'h3C, QRY_LIGHT, 8'h8D);
		cyc(300);
		`CHK(i_ssfo_host.got.size(), 0)
		`CHK(qerr_cnt - q0, 1)
		$display("test query done");
		// Bus mode refuses, the request waits for serial mode
		sel = 1'b0;
		cyc(6);
		`CHK(tx_oe_n, 1'b1)
		`CHK({rx_out, rx_oe_n, ac_out, ad_out}, 4'hC)
		c_light = 1'b1;
		lux = $urandom();
		pulse_upd();
		c_light = 1'b0;
		cyc(300);
		`CHK(i_ssfo_host.got.size(), 0)
		sel = 1'b1;
		cyc(6);
		`CHK(tx_oe_n, 1'b0)
		expect_frame(TYPE_LIGHT, 4, {48'h0, lux});
		$display("test bus mode done");
		// Bypass passes the raw bus both ways
		byp = 1'b0;
		pull_c = 1'b1;
		ad_ext = 1'b0;
		cyc(6);
		`CHK(ac_oe_n, 1'b0)
		`CHK(ad_oe_n, 1'b1)
		`CHK(d_seen, 1'b0)
		`CHK(c_seen, 1'b0)
		byp = 1'b1;
		pull_d = 1'b1;
		cyc(6);
		`CHK(byp_m, 1'b0)
		`CHK(ac_oe_n & ad_oe_n, 1'b1)
		`CHK(d_seen, 1'b1)
		{pull_c, pull_d, ad_ext} = 3'b001;
		$display("test bypass done");
		// Fast rate: start bit plus low first header bit span two periods
		fast = 1'b1;
		c_light = 1'b1;
		pulse_upd();
		k = 0;
		while (tx_pin !== 1'b0 && k < 50) begin cyc(1); k++; end
		k = 0;
		while (tx_pin === 1'b0 && k < 4000) begin cyc(1); k++; end
		`CHK(k, 2 * BAUD_FAST_DIV)
		// Reset in mid-frame, then a clean frame at the slow rate
		sys_rst = 1'b1;
		fast = 1'b0;
		cyc(2);
		`CHK({tx_out, tx_oe_n, busy}, 3'b110)
		sys_rst = 1'b0;
		cyc(300);
		i_ssfo_host.got.delete();
		pulse_upd();
		c_light = 1'b0;
		expect_frame(TYPE_LIGHT, 4, {48'h0, lux});
		$display("test rate and reset done");
		summarize();
	end
	// Watchdog against a hang, inside the cycle budget
	initial begin
		#900000;
		failures++;
		$display("MISMATCH t=%0t watchdog", $time);
		summarize();
	end
endmodule : tb_top
bind ssfo_top ssfo_chk #(.SLOW_DIV(SLOW_DIV)) i_ssfo_chk (.*);
